// ---- design/dtf_pkg.sv ----
// Package: register layout, register selects and trace field encodings for the debug config slice
package dtf_pkg;
   // ==========================================
   // Debug register selects
   typedef enum logic {
      DTF_SEL_TRACE,
      DTF_SEL_DIVIDER
   } dtf_sel_e;

   // ==========================================
   // Flash divider register layout
   localparam int          DIV_PRESCALE_BIT = 30;
   localparam int          DIV_DIVISOR_LSB  = 24;
   localparam int          DIV_DIVISOR_W    = 6;
   localparam int          DIV_BYTE_LSB     = 24;
   localparam logic [31:0] DIV_RESET        = 32'h0000_0000;
   localparam logic [31:0] DIV_WRITE_MASK   = 32'h7F00_0000;
   localparam int          PRESCALE_RATIO   = 8;

   // ==========================================
   // Trace configuration register layout
   localparam int          TRC_MODE_LSB     = 0;
   localparam int          TRC_SS_LSB       = 2;
   localparam logic [31:0] TRC_RESET        = 32'h0000_0000;
   localparam logic [31:0] TRC_WRITE_MASK   = 32'h0000_001F;

   // ==========================================
   // Trace recording modes and start/stop selections
   localparam logic [1:0]  TRC_MODE_NORMAL  = 2'h0;
   localparam logic [2:0]  TRC_SS_DISABLED  = 3'h0;
   localparam logic [2:0]  TRC_SS_ALWAYS    = 3'h1;

   // ==========================================
   // Breakpoint groups: bit positions in start, stop and hit vectors
   localparam int          BP_GROUPS        = 4;
   localparam int          BP_ADDR          = 0;
   localparam int          BP_DATA          = 1;
   localparam int          BP_PC0           = 2;
   localparam int          BP_PC1           = 3;
endpackage

// ---- design/dtf_flash_clk_div.sv ----
// Flash clock divider: bus clock optionally divided by eight, then by divisor plus one
`timescale 1ns/1ns
module dtf_flash_clk_div #(
   parameter int DIV_W = dtf_pkg::DIV_DIVISOR_W
) (
   input  wire logic             ref_clk,
   input  wire logic             rstn,
   input  wire logic             prescale_eight,
   input  wire logic [DIV_W-1:0] divisor,
   output logic                  flash_clk_tick,
   output logic                  flash_clk
);
   localparam logic [2:0] PRE_LAST = 3'(dtf_pkg::PRESCALE_RATIO - 1);

   logic [2:0]       pre_q;
   logic [2:0]       pre_d;
   logic [DIV_W-1:0] cnt_q;
   logic [DIV_W-1:0] cnt_d;
   logic             tick_q;
   logic             clk_q;

   wire pre_tick = !prescale_eight || (pre_q >= PRE_LAST);      // R11
   wire cnt_wrap = pre_tick && (cnt_q >= divisor);              // R11

   assign pre_d = pre_tick ? 3'h0 : pre_q + 3'h1;
   assign cnt_d = !pre_tick ? cnt_q : (cnt_wrap ? '0 : cnt_q + DIV_W'(1));
   assign flash_clk_tick = tick_q;
   assign flash_clk      = clk_q;

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         pre_q  <= 3'h0;
         cnt_q  <= '0;
         tick_q <= 1'b0;
         clk_q  <= 1'b0;
      end else begin
         pre_q  <= pre_d;
         cnt_q  <= cnt_d;
         tick_q <= cnt_wrap;
         if (cnt_wrap) begin
            clk_q <= !clk_q;
         end
      end
   end
endmodule

// ---- design/dtf_debug_cfg.sv ----
// Debug configuration slice: trace start/stop control and flash divider register
//
// How it works
// [R1] Trace record mode 00 is normal; start and stop follow the start/stop field.
// [R2] Start/stop 000 disables trace, 001 records always, others use breakpoint matches.
// [R3] Breakpoint groups not consumed by trace still raise ordinary debug triggers.
// [R4] Divider register holds the flash clock divider used for debugger flash operations.
// [R5] Byte read returns divider bits 31-24, accepted in every mode.
// [R6] Byte write loads divider bits 31-24, accepted in every mode.
// [R7] Register read returns all 32 divider bits without halting the core.
// [R8] Register write updates all 32 divider bits without halting the core.
// [R9] Core debug-register writes aimed at the divider are ignored.
// [R10] Prescale select at bit 30, divisor bits 29-24, rest reads zero, reset zero.
// [R11] Flash clock is bus clock over divisor plus one, first over eight if selected.
// [R12] Host loads divider values for a 150 to 200 kHz flash clock before erasing.
`timescale 1ns/1ns
module dtf_debug_cfg #(
   parameter int NUM_BP = dtf_pkg::BP_GROUPS
) (
   input  wire logic              ref_clk,
   input  wire logic              rstn,
   input  wire logic              read_divider_byte_cmd,
   input  wire logic              write_divider_byte_cmd,
   input  wire logic [7:0]        wr_byte,
   input  wire logic              read_debug_reg_cmd,
   input  wire logic              write_debug_reg_cmd,
   input  wire dtf_pkg::dtf_sel_e dreg_sel,
   input  wire logic [31:0]       wr_data,
   input  wire logic              core_debug_write_instr,
   input  wire dtf_pkg::dtf_sel_e core_sel,
   input  wire logic [31:0]       core_wr_data,
   input  wire logic [NUM_BP-1:0] bp_hit,
   output logic [31:0]            rd_data,
   output logic                   rd_valid,
   output logic                   core_write_ignored,
   output logic                   trace_recording,
   output logic [NUM_BP-1:0]      debug_trigger,
   output logic [1:0]             trace_record_mode,
   output logic [2:0]             trace_start_stop_select,
   output logic                   flash_clk_prescale_eight,
   output logic [5:0]             flash_clk_divisor,
   output logic                   flash_clk_tick,
   output logic                   flash_clk
);
   // ==========================================
   // Breakpoint usage per start/stop selection
   typedef struct packed {
      logic [NUM_BP-1:0] start;
      logic [NUM_BP-1:0] stop;
   } dtf_bp_use_s;

   function automatic dtf_bp_use_s bp_use(input logic [2:0] ss);
      dtf_bp_use_s u;
      u = '0;
      unique case (ss)
         3'h2: begin
            u.start[dtf_pkg::BP_ADDR] = 1'b1;
         end
         3'h3: begin
            u.stop[dtf_pkg::BP_ADDR] = 1'b1;
         end
         3'h4: begin
            u.start[dtf_pkg::BP_PC0] = 1'b1;
            u.stop[dtf_pkg::BP_ADDR] = 1'b1;
            u.stop[dtf_pkg::BP_DATA] = 1'b1;
         end
         3'h5: begin
            u.start[dtf_pkg::BP_PC1] = 1'b1;
         end
         3'h6: begin
            u.start[dtf_pkg::BP_ADDR] = 1'b1;
            u.start[dtf_pkg::BP_DATA] = 1'b1;
         end
         3'h7: begin
            u.start[dtf_pkg::BP_PC0] = 1'b1;
            u.stop[dtf_pkg::BP_PC1]  = 1'b1;
         end
         default: begin
            u = '0;
         end
      endcase
      return u;
   endfunction

   // ==========================================
   // Registers
   logic [31:0]       div_q;
   logic [31:0]       div_d;
   logic [31:0]       trc_q;
   logic [31:0]       trc_d;
   logic [31:0]       rd_data_q;
   logic [31:0]       rd_data_d;
   logic              rd_valid_q;
   logic              ign_q;
   logic              rec_q;
   logic              rec_d;
   logic [NUM_BP-1:0] trig_q;

   // ==========================================
   // Command decode
   wire dreg_wr_div = write_debug_reg_cmd && (dreg_sel == dtf_pkg::DTF_SEL_DIVIDER);
   wire dreg_wr_trc = write_debug_reg_cmd && (dreg_sel == dtf_pkg::DTF_SEL_TRACE);
   wire dreg_rd_div = read_debug_reg_cmd && (dreg_sel == dtf_pkg::DTF_SEL_DIVIDER);
   wire core_wr_div = core_debug_write_instr && (core_sel == dtf_pkg::DTF_SEL_DIVIDER);
   wire core_wr_trc = core_debug_write_instr && (core_sel == dtf_pkg::DTF_SEL_TRACE);
   wire [31:0] byte_word = {wr_byte, 24'h00_0000};

   // Host register write wins over byte write; core writes never touch the divider
   assign div_d = dreg_wr_div ? (wr_data & dtf_pkg::DIV_WRITE_MASK)         // R8 R10
                : write_divider_byte_cmd ? (byte_word & dtf_pkg::DIV_WRITE_MASK) // R6 R10
                : div_q;                                                 // R9

   // Trace config takes host and core register writes, host first
   assign trc_d = dreg_wr_trc ? (wr_data & dtf_pkg::TRC_WRITE_MASK)
                : core_wr_trc ? (core_wr_data & dtf_pkg::TRC_WRITE_MASK)
                : trc_q;

   // ==========================================
   // Read path
   wire [7:0] div_byte = div_q[dtf_pkg::DIV_BYTE_LSB +: 8];
   wire rd_any = read_divider_byte_cmd || read_debug_reg_cmd;

   assign rd_data_d = read_divider_byte_cmd ? {24'h00_0000, div_byte}      // R5
                    : dreg_rd_div ? div_q                                // R7
                    : read_debug_reg_cmd ? trc_q
                    : rd_data_q;

   // ==========================================
   // Trace start/stop control
   wire [1:0]   mode_w = trc_q[dtf_pkg::TRC_MODE_LSB +: 2];
   wire [2:0]   ss_w   = trc_q[dtf_pkg::TRC_SS_LSB +: 3];
   dtf_bp_use_s use_w;
   assign use_w = bp_use(ss_w);
   wire [NUM_BP-1:0] used_w   = use_w.start | use_w.stop;
   wire              start_hit = |(bp_hit & use_w.start);
   wire              stop_hit  = |(bp_hit & use_w.stop);
   wire              mode_norm = (mode_w == dtf_pkg::TRC_MODE_NORMAL);

   always_comb begin
      rec_d = rec_q;
      if (!mode_norm || ss_w == dtf_pkg::TRC_SS_DISABLED) begin     // R1 R2
         rec_d = 1'b0;
      end else if (ss_w == dtf_pkg::TRC_SS_ALWAYS) begin              // R2
         rec_d = 1'b1;
      end else if (stop_hit) begin                                     // R2
         rec_d = 1'b0;
      end else if (start_hit) begin                                    // R2
         rec_d = 1'b1;
      end
   end

   // ==========================================
   // Register flops
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         div_q <= dtf_pkg::DIV_RESET;                                  // R10
         trc_q <= dtf_pkg::TRC_RESET;
      end else begin
         div_q <= div_d;                                               // R4
         trc_q <= trc_d;
      end
   end

   // ==========================================
   // Read answer flops
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rd_data_q  <= 32'h0000_0000;
         rd_valid_q <= 1'b0;
      end else begin
         rd_data_q  <= rd_data_d;
         rd_valid_q <= rd_any;
      end
   end

   // ==========================================
   // Status and trigger flops
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         ign_q  <= 1'b0;
         rec_q  <= 1'b0;
         trig_q <= '0;
      end else begin
         ign_q  <= core_wr_div;                                        // R9
         rec_q  <= rec_d;
         trig_q <= bp_hit & ~used_w;                                   // R3
      end
   end

   // ==========================================
   // Divider fields
   wire       div_prescale = div_q[dtf_pkg::DIV_PRESCALE_BIT];
   wire [5:0] div_divisor  = div_q[dtf_pkg::DIV_DIVISOR_LSB +: dtf_pkg::DIV_DIVISOR_W];

   // ==========================================
   // Flash clock generation
   dtf_flash_clk_div #(
      .DIV_W (dtf_pkg::DIV_DIVISOR_W)
   ) u_fclk (
      .ref_clk        (ref_clk),
      .rstn           (rstn),
      .prescale_eight (div_prescale),                                  // R11
      .divisor        (div_divisor),                                   // R11
      .flash_clk_tick (flash_clk_tick),
      .flash_clk      (flash_clk)
   );

   // ==========================================
   // Outputs
   assign rd_data                  = rd_data_q;
   assign rd_valid                 = rd_valid_q;
   assign core_write_ignored       = ign_q;
   assign trace_recording          = rec_q;
   assign debug_trigger            = trig_q;
   assign trace_record_mode        = mode_w;
   assign trace_start_stop_select  = ss_w;
   assign flash_clk_prescale_eight = div_prescale;
   assign flash_clk_divisor        = div_divisor;
endmodule

// ---- testbench/dtf_debug_cfg_monitor.sv ----
// Checker for the divider and trace configuration ports
`timescale 1ns/1ns
module dtf_debug_cfg_monitor #(
   parameter int NUM_BP = 4
) (
   input wire logic              ref_clk,
   input wire logic              rstn,
   input wire logic              read_divider_byte_cmd,
   input wire logic              write_divider_byte_cmd,
   input wire logic [7:0]        wr_byte,
   input wire logic              read_debug_reg_cmd,
   input wire logic              write_debug_reg_cmd,
   input wire dtf_pkg::dtf_sel_e dreg_sel,
   input wire logic [31:0]       wr_data,
   input wire logic              core_debug_write_instr,
   input wire dtf_pkg::dtf_sel_e core_sel,
   input wire logic [NUM_BP-1:0] bp_hit,
   input wire logic [31:0]       rd_data,
   input wire logic              rd_valid,
   input wire logic              core_write_ignored,
   input wire logic              trace_recording,
   input wire logic [NUM_BP-1:0] debug_trigger,
   input wire logic [1:0]        trace_record_mode,
   input wire logic [2:0]        trace_start_stop_select,
   input wire logic              flash_clk_prescale_eight,
   input wire logic [5:0]        flash_clk_divisor,
   input wire logic              flash_clk_tick
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   // ==========================================
   // Tick spacing and divider change tracking
   logic [9:0] gap_q, stab_q;
   wire        div_sel = (dreg_sel == dtf_pkg::DTF_SEL_DIVIDER);
   wire        div_chg = write_divider_byte_cmd | (write_debug_reg_cmd & div_sel);
   wire [9:0]  one_gap = 10'(flash_clk_divisor) + 10'h001;
   wire [9:0]  exp_gap = flash_clk_prescale_eight ? 10'(one_gap * 8) : one_gap;
   wire [2:0]  ss_q = trace_start_stop_select;
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         gap_q  <= 10'h000;
         stab_q <= 10'h000;
      end else begin
         gap_q  <= flash_clk_tick ? 10'h000 : gap_q + 10'h001;
         stab_q <= div_chg ? 10'h000 : (stab_q == 10'h3FF ? stab_q : stab_q + 10'h001);
      end
   end
   // ==========================================
   // Assertions
   chk_byte_read: assert property (read_divider_byte_cmd |=> rd_valid && rd_data ==
      {24'h00_0000, 1'b0, $past(flash_clk_prescale_eight), $past(flash_clk_divisor)})
      else $error("byte read answer wrong");
   chk_reg_read: assert property (read_debug_reg_cmd && !read_divider_byte_cmd && div_sel
      |=> rd_valid && rd_data ==
      {1'b0, $past(flash_clk_prescale_eight), $past(flash_clk_divisor), 24'h00_0000})
      else $error("register read answer wrong");
   chk_byte_write: assert property (write_divider_byte_cmd &&
      !(write_debug_reg_cmd && div_sel)
      |=> {1'b0, flash_clk_prescale_eight, flash_clk_divisor} == ($past(wr_byte) & 8'h7F))
      else $error("byte write not loaded");
   chk_reg_write: assert property (write_debug_reg_cmd && div_sel |=>
      {1'b0, flash_clk_prescale_eight, flash_clk_divisor, 24'h00_0000}
      == ($past(wr_data) & dtf_pkg::DIV_WRITE_MASK)) else $error("register write not loaded");
   chk_core_ignored: assert property (core_debug_write_instr && core_sel ==
      dtf_pkg::DTF_SEL_DIVIDER && !div_chg |=> core_write_ignored
      && $stable(flash_clk_divisor) && $stable(flash_clk_prescale_eight))
      else $error("core write changed divider");
   chk_tick_gap: assert property (flash_clk_tick && stab_q > 10'h21C |->
      gap_q == exp_gap - 10'h001) else $error("flash tick spacing wrong");
   chk_trace_off: assert property (ss_q == 3'h0 && $past(ss_q) == 3'h0
      |-> !trace_recording) else $error("trace records while disabled");
   chk_trace_always: assert property (ss_q == 3'h1 && $past(ss_q) == 3'h1 &&
      trace_record_mode == 2'h0 && $past(trace_record_mode) == 2'h0 |-> trace_recording)
      else $error("unconditional trace not recording");
   chk_trigger_free: assert property (ss_q == 3'h0 && $past(ss_q) == 3'h0
      |-> debug_trigger == $past(bp_hit)) else $error("free trigger not passed");
   cover property (write_divider_byte_cmd);
   cover property (core_write_ignored);
   cover property (flash_clk_tick && stab_q > 10'h21C);
   cover property (trace_recording && ss_q > 3'h1);
endmodule

// ---- testbench/dtf_host_model.sv ----
// Debug host adapter model issuing divider and trace register commands
`timescale 1ns/1ns
module dtf_host_model (
   input  wire logic        ref_clk,
   input  wire logic [31:0] rd_data,
   input  wire logic        rd_valid,
   output logic             read_divider_byte_cmd,
   output logic             write_divider_byte_cmd,
   output logic [7:0]       wr_byte,
   output logic             read_debug_reg_cmd,
   output logic             write_debug_reg_cmd,
   output dtf_pkg::dtf_sel_e dreg_sel,
   output logic [31:0]      wr_data
);
   initial begin
      {read_divider_byte_cmd, write_divider_byte_cmd} = 2'h0;
      {read_debug_reg_cmd, write_debug_reg_cmd} = 2'h0;
      wr_byte = 8'h00;
      wr_data = 32'h0000_0000;
      dreg_sel = dtf_pkg::DTF_SEL_TRACE;
   end
   // Op 0 byte read, 1 byte write, 2 register read, 3 register write
   task automatic xfer(input logic [1:0] op, input dtf_pkg::dtf_sel_e sel,
                       input logic [31:0] data, output logic [31:0] rd, output logic ok);
      @(negedge ref_clk);
      dreg_sel = sel;
      wr_data = data;
      wr_byte = data[7:0];
      read_divider_byte_cmd = (op == 2'h0);
      write_divider_byte_cmd = (op == 2'h1);
      read_debug_reg_cmd = (op == 2'h2);
      write_debug_reg_cmd = (op == 2'h3);
      @(negedge ref_clk);
      ok = op[0] | (rd_valid === 1'b1);
      rd = rd_data;
      {read_divider_byte_cmd, write_divider_byte_cmd} = 2'h0;
      {read_debug_reg_cmd, write_debug_reg_cmd} = 2'h0;
      // Released data lines show the inverse of the last value
      wr_data = ~data;
      wr_byte = ~data[7:0];
   endtask
   // Prescale on, divisor 62: 100 MHz / 504 lies inside the erase clock band
   task automatic set_erase_clk(output logic [31:0] rd, output logic ok);
      xfer(2'h1, dtf_pkg::DTF_SEL_DIVIDER, 32'h0000_007E, rd, ok);
   endtask
endmodule

// ---- testbench/tb_top.sv ----
// Testbench for the debug configuration slice
`timescale 1ns/1ns
module tb_top;
   logic              ref_clk, rstn, read_divider_byte_cmd, write_divider_byte_cmd, ok;
   logic              read_debug_reg_cmd, write_debug_reg_cmd, core_debug_write_instr;
   logic              rd_valid, core_write_ignored, trace_recording, flash_clk;
   logic              flash_clk_prescale_eight, flash_clk_tick;
   logic [7:0]        wr_byte;
   logic [31:0]       wr_data, core_wr_data, rd_data, rd;
   logic [3:0]        bp_hit, debug_trigger;
   logic [1:0]        trace_record_mode;
   logic [2:0]        trace_start_stop_select;
   logic [5:0]        flash_clk_divisor;
   dtf_pkg::dtf_sel_e dreg_sel, core_sel;
   int                n_errors, check_count;
   localparam dtf_pkg::dtf_sel_e DV = dtf_pkg::DTF_SEL_DIVIDER;
   localparam dtf_pkg::dtf_sel_e TR = dtf_pkg::DTF_SEL_TRACE;
   dtf_debug_cfg  i_dut (.*);
   dtf_host_model i_host (.*);
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   task automatic results();
      if (n_errors == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic rchk(input logic [1:0] op, input dtf_pkg::dtf_sel_e sel, input logic [31:0] exp);
      i_host.xfer(op, sel, 32'h0000_0000, rd, ok);
      chk(ok ? rd : ~exp, exp);
   endtask
   task automatic tick_gap(input logic [31:0] exp);
      int   n;
      int   t;
      logic lvl;
      n = 0;
      t = 0;
      lvl = 1'b0;
      for (int i = 0; i < 1600 && t < 3; i++) begin
         @(negedge ref_clk);
         if (t == 2) n++;
         if (flash_clk_tick === 1'b1) begin
            if (t == 2) chk({31'h0, flash_clk}, {31'h0, ~lvl});
            lvl = flash_clk;
            t++;
         end
      end
      if (t < 3) begin
         chk(32'h0000_0000, 32'h0000_0001);
         results();
      end else begin
         chk(32'(n), exp);
      end
   endtask
   initial begin
      {rstn, core_debug_write_instr} = 2'h0;
      n_errors = 0;
      check_count = 0;
      core_sel = TR;
      core_wr_data = 32'hFFFF_FFFF;
      bp_hit = 4'h0;
      repeat (5) @(negedge ref_clk);
      rstn = 1'b1;
      rchk(2'h2, DV, 32'h0000_0000);
      rchk(2'h2, TR, 32'h0000_0000);
      i_host.xfer(2'h1, DV, 32'h0000_00C5, rd, ok);
      rchk(2'h0, DV, 32'h0000_0045);
      rchk(2'h2, DV, 32'h4500_0000);
      i_host.xfer(2'h3, DV, 32'hFFFF_FFFF, rd, ok);
      rchk(2'h2, DV, 32'h7F00_0000);
      rchk(2'h0, DV, 32'h0000_007F);
      @(negedge ref_clk);
      core_sel = DV;
      core_debug_write_instr = 1'b1;
      @(negedge ref_clk);
      core_debug_write_instr = 1'b0;
      chk({31'h0, core_write_ignored}, 32'h0000_0001);
      rchk(2'h2, DV, 32'h7F00_0000);
      core_sel = TR;
      core_debug_write_instr = 1'b1;
      @(negedge ref_clk);
      core_debug_write_instr = 1'b0;
      chk({31'h0, core_write_ignored}, 32'h0000_0000);
      rchk(2'h2, TR, 32'h0000_001F);
      i_host.xfer(2'h3, TR, 32'h0000_0004, rd, ok);
      rchk(2'h2, TR, 32'h0000_0004);
      chk({31'h0, trace_recording}, 32'h0000_0001);
      i_host.xfer(2'h3, TR, 32'h0000_0005, rd, ok);
      @(negedge ref_clk);
      chk({31'h0, trace_recording}, 32'h0000_0000);
      i_host.xfer(2'h3, TR, 32'hFFFF_FFE0, rd, ok);
      rchk(2'h2, TR, 32'h0000_0000);
      chk({31'h0, trace_recording}, 32'h0000_0000);
      bp_hit = 4'hF;
      @(negedge ref_clk);
      bp_hit = 4'h0;
      chk({28'h0, debug_trigger}, 32'h0000_000F);
      i_host.xfer(2'h3, TR, 32'h0000_0008, rd, ok);
      chk({31'h0, trace_recording}, 32'h0000_0000);
      bp_hit = 4'hF;
      @(negedge ref_clk);
      bp_hit = 4'h0;
      chk({31'h0, trace_recording}, 32'h0000_0001);
      chk({28'h0, debug_trigger}, 32'h0000_000E);
      i_host.xfer(2'h3, TR, 32'h0000_000C, rd, ok);
      chk({27'h0, trace_start_stop_select, trace_record_mode}, 32'h0000_000C);
      chk({31'h0, trace_recording}, 32'h0000_0001);
      bp_hit = 4'h1;
      @(negedge ref_clk);
      bp_hit = 4'h0;
      chk({31'h0, trace_recording}, 32'h0000_0000);
      i_host.xfer(2'h3, DV, 32'h0500_0000, rd, ok);
      tick_gap(32'h0000_0006);
      i_host.set_erase_clk(rd, ok);
      tick_gap(32'h0000_01F8);
      rstn = 1'b0;
      repeat (5) @(negedge ref_clk);
      rstn = 1'b1;
      rchk(2'h2, DV, 32'h0000_0000);
      rchk(2'h2, TR, 32'h0000_0000);
      results();
   end
endmodule
bind dtf_debug_cfg dtf_debug_cfg_monitor #(.NUM_BP(NUM_BP)) i_mon (.*);
